// *** amp_protect_defines.vh ***
// Constants for the amplifier fault supervisor: register offsets, error vector
// layout, reset values, thresholds and timing figures. Included by the fault supervisor only.
// Assumes a 50 MHz core clock and digital temperature and supply codes from on-chip converters.
//
// Functional notes
// - While switching, watch forward current of every switch that is on.
// - Over-current or short: latch it, stop the power stage, flag the fault pin.
// - By default restart by itself after an over-current shutdown.
// - Check pin-to-pin shorts before switching; refuse to start when one is found.
// - Temperature warning sets bit 4 of the live error register at 124.
// - Temperature error sets bit 5, stops switching, resumes after cooling.
// - Temperature error sets at 150 C and clears at 135 C.
// - Temperature warning sets at 125 C and clears at 105 C.
// - Fault pin is active while warning or error temperature flag is set.
// - Supply lockouts: core and analog 4.2/4.0 V, stage supply 4.3/4.1 V.
// - DC fault only after output outside 0.37..0.63 band for over 700 ms.
// - DC fault stops the stage, drives the fault pin, shows in error register.
// - After DC fault restart only on enable cycling or history-clear toggle.
// - DC protection on after reset; clearing bit 2 of register 0x26 disables it.
// - Fault pin pulled low whenever any error source is active.
// - Error vector: DC 7, short 6, temp error 5, warning 4, UV 3, clock 2, OC 1, cap 0.
// - Accumulated error register at 109 collects all errors; history-clear toggle keeps only the errors live in that cycle.

`ifndef AMP_PROTECT_DEFINES_VH
`define AMP_PROTECT_DEFINES_VH

`define ADDR_DC_SHUTDOWN_CTRL 7'h26
`define ADDR_ERR_HIST_CTRL 7'h2D
`define ADDR_INT_ENABLE 7'h51
`define ADDR_INT_CLEAR 7'h52
`define ADDR_PROT_CTRL 7'h53
`define ADDR_ERR_ACC 7'h6D
`define ADDR_ERR_LIVE 7'h7C
`define ADDR_INT_STATUS 7'h7D

`define DC_SHUTDOWN_CTRL_RESET 8'h04
`define ERR_HIST_CTRL_RESET 8'h00
`define PROT_CTRL_RESET 8'h00
`define INT_ENABLE_RESET 8'h00

`define DC_FAULT_BIT_EN_BIT 2
`define HIST_CLEAR_BIT 2
`define OC_LATCH_MODE_BIT 0

`define ERR_DC_BIT 7
`define ERR_SHORT_BIT 6
`define ERR_TEMP_ERR_BIT 5
`define ERR_TEMP_WARN_BIT 4
`define ERR_UV_BIT 3
`define ERR_CLOCK_BIT 2
`define ERR_OC_BIT 1
`define ERR_FLYCAP_BIT 0

`define TEMP_ERR_SET 8'h96
`define TEMP_ERR_CLR 8'h87
`define TEMP_WARN_SET 8'h7D
`define TEMP_WARN_CLR 8'h69

`define CORE_UV_LOCK_MV 13'h0FA0
`define CORE_UV_RELEASE_MV 13'h1068
`define STAGE_UV_LOCK_MV 13'h1004
`define STAGE_UV_RELEASE_MV 13'h10CC

`define CLK_FREQ_KHZ 50000
`define CLK_FREQ_MHZ 50
`define DC_PERSIST_MS 700
`define OC_RESTART_US 100
`define SHORT_CHECK_US 2

`define PIN_SYNC_INIT 15'h4000

`endif

// *** pin_sync.v ***
// Three-stage synchroniser for a group of asynchronous comparator and pin inputs.
// Assumes every bit may change at any time relative to clock.
`timescale 1ns/1ps
module pin_sync #(
	parameter WIDTH = 1,
	parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
	input wire clock,
	input wire reset,
	input wire [WIDTH-1:0] pinIn,
	output reg [WIDTH-1:0] pinOut
);
	reg [WIDTH-1:0] stage1_reg;
	reg [WIDTH-1:0] stage2_reg;
	reg [WIDTH-1:0] stage3_reg;
	wire [WIDTH-1:0] agree;

	// A bit is taken over only when stages two and three agree, which filters single-cycle noise.
	assign agree = ~(stage2_reg ^ stage3_reg);

	always @(posedge clock) begin
		if (reset) begin
			stage1_reg <= INIT;
			stage2_reg <= INIT;
			stage3_reg <= INIT;
			pinOut <= INIT;
		end else begin
			stage1_reg <= pinIn;
			stage2_reg <= stage1_reg;
			stage3_reg <= stage2_reg;
			pinOut <= (stage3_reg & agree) | (pinOut & ~agree);
		end
	end
endmodule

// *** hysteresis_flag.v ***
// Threshold detector with hysteresis on a digital measurement code.
// Assumes the code comes from logic on the same clock.
`timescale 1ns/1ps
module hysteresis_flag #(
	parameter WIDTH = 8,
	parameter [WIDTH-1:0] SET_LEVEL = {WIDTH{1'b0}},
	parameter [WIDTH-1:0] CLR_LEVEL = {WIDTH{1'b0}},
	parameter RISING = 1,
	parameter RESET_FLAG = 0
) (
	input wire clock,
	input wire reset,
	input wire [WIDTH-1:0] value,
	output reg flag
);
	wire setHit;
	wire clrHit;

	// Rising detectors set at or above the set level; falling ones at or below it.
	assign setHit = (RISING != 0) ? (value >= SET_LEVEL) : (value <= SET_LEVEL);
	assign clrHit = (RISING != 0) ? (value <= CLR_LEVEL) : (value >= CLR_LEVEL);

	always @(posedge clock) begin
		if (reset) begin
			flag <= (RESET_FLAG != 0);
		end else if (setHit) begin
			flag <= 1'b1;
		end else if (clrHit) begin
			flag <= 1'b0;
		end
	end
endmodule

// *** amp_fault_manager.v ***
// Fault supervisor for a multi-level audio power stage: start-up short check, over-current
// shutdown and restart, temperature and supply lockouts, DC persistence, error registers,
// open-drain fault pin and a level interrupt.
// Assumes comparator inputs and the enable pin are asynchronous; measurement codes, the
// switch-on vector and the clock-lock flag come from logic on the same clock.
`timescale 1ns/1ps
`include "amp_protect_defines.vh"
module amp_fault_manager #(
	parameter [31:0] DC_PERSIST_CYCLES = `DC_PERSIST_MS * `CLK_FREQ_KHZ,
	parameter [31:0] OC_RESTART_CYCLES = `OC_RESTART_US * `CLK_FREQ_MHZ
) (
	input wire clock,
	input wire reset,
	input wire [6:0] regAddr,
	input wire [7:0] regWrData,
	input wire regWrite,
	input wire regRead,
	output reg [7:0] regRdData,
	input wire [7:0] tempCode,
	input wire [12:0] dvddMv,
	input wire [12:0] avddMv,
	input wire [12:0] pvddMv,
	input wire enableN,
	input wire [3:0] outputSwitchNodeOc,
	input wire [3:0] switchOn,
	input wire pinShortDetect,
	input wire [3:0] dcHighCmp,
	input wire [3:0] dcLowCmp,
	input wire flyCapFault,
	input wire pllUnlocked,
	output reg switchEnable,
	output reg shortCheckEnable,
	output wire errorPinOut,
	output reg errorPinOe,
	output reg irq
);
	localparam [31:0] SHORT_CHECK_CYCLES = `SHORT_CHECK_US * `CLK_FREQ_MHZ;

	localparam [2:0] S_OFF = 3'h0;
	localparam [2:0] S_CHECK = 3'h1;
	localparam [2:0] S_RUN = 3'h2;
	localparam [2:0] S_OC_HOLD = 3'h3;
	localparam [2:0] S_LATCHED = 3'h4;

	function wrHit;
		input [6:0] addr;
		input [6:0] target;
		input strobe;
		begin
			wrHit = strobe && (addr == target);
		end
	endfunction

	// Synchronised pins.
	wire [14:0] pinRaw;
	wire [14:0] pinSync;
	wire enableNSync;
	wire [3:0] ocSync;
	wire shortSync;
	wire [3:0] dcHighSync;
	wire [3:0] dcLowSync;
	wire flyCapSync;

	assign pinRaw = {enableN, outputSwitchNodeOc, pinShortDetect, dcHighCmp, dcLowCmp, flyCapFault};
	assign enableNSync = pinSync[14];
	assign ocSync = pinSync[13:10];
	assign shortSync = pinSync[9];
	assign dcHighSync = pinSync[8:5];
	assign dcLowSync = pinSync[4:1];
	assign flyCapSync = pinSync[0];

	pin_sync #(
		.WIDTH(15),
		.INIT(`PIN_SYNC_INIT)
	) pinSyncInst (
		.clock(clock),
		.reset(reset),
		.pinIn(pinRaw),
		.pinOut(pinSync)
	);

	// Temperature and supply monitors.
	wire tempErrorFlag;
	wire tempWarningFlag;
	wire dvddLow;
	wire avddLow;
	wire pvddLow;
	wire uvAny;

	hysteresis_flag #(
		.WIDTH(8),
		.SET_LEVEL(`TEMP_ERR_SET),
		.CLR_LEVEL(`TEMP_ERR_CLR),
		.RISING(1),
		.RESET_FLAG(0)
	) tempErrInst (
		.clock(clock),
		.reset(reset),
		.value(tempCode),
		.flag(tempErrorFlag)
	);

	hysteresis_flag #(
		.WIDTH(8),
		.SET_LEVEL(`TEMP_WARN_SET),
		.CLR_LEVEL(`TEMP_WARN_CLR),
		.RISING(1),
		.RESET_FLAG(0)
	) tempWarnInst (
		.clock(clock),
		.reset(reset),
		.value(tempCode),
		.flag(tempWarningFlag)
	);

	// Supplies start locked out so that nothing switches before the first valid measurement.
	hysteresis_flag #(
		.WIDTH(13),
		.SET_LEVEL(`CORE_UV_LOCK_MV),
		.CLR_LEVEL(`CORE_UV_RELEASE_MV),
		.RISING(0),
		.RESET_FLAG(1)
	) dvddInst (
		.clock(clock),
		.reset(reset),
		.value(dvddMv),
		.flag(dvddLow)
	);

	hysteresis_flag #(
		.WIDTH(13),
		.SET_LEVEL(`CORE_UV_LOCK_MV),
		.CLR_LEVEL(`CORE_UV_RELEASE_MV),
		.RISING(0),
		.RESET_FLAG(1)
	) avddInst (
		.clock(clock),
		.reset(reset),
		.value(avddMv),
		.flag(avddLow)
	);

	hysteresis_flag #(
		.WIDTH(13),
		.SET_LEVEL(`STAGE_UV_LOCK_MV),
		.CLR_LEVEL(`STAGE_UV_RELEASE_MV),
		.RISING(0),
		.RESET_FLAG(1)
	) pvddInst (
		.clock(clock),
		.reset(reset),
		.value(pvddMv),
		.flag(pvddLow)
	);

	assign uvAny = dvddLow | avddLow | pvddLow;

	// Registers.
	reg [7:0] dcShutdownCtrl_reg;
	reg [7:0] histCtrl_reg;
	reg [7:0] protCtrl_reg;
	reg [7:0] intEnable_reg;
	reg [7:0] intStatus_reg;
	reg [7:0] errAcc_reg;
	reg histClearPulse;
	wire dcProtEnable;
	wire ocLatchMode;

	assign dcProtEnable = dcShutdownCtrl_reg[`DC_FAULT_BIT_EN_BIT];
	assign ocLatchMode = protCtrl_reg[`OC_LATCH_MODE_BIT];

	// Protection state.
	reg [2:0] state_reg;
	reg [2:0] state_next;
	reg [31:0] timer_reg;
	reg [31:0] timer_next;
	reg dcLatched_reg;
	reg shortLatched_reg;
	reg ocLatched_reg;
	wire [3:0] dcTrip;
	wire switching;
	wire ocEvent;
	wire holdOff;
	wire clearEvent;
	wire [7:0] errLive;

	assign switching = (state_reg == S_RUN);
	assign ocEvent = switching && ((ocSync & switchOn) != 4'h0);
	assign holdOff = tempErrorFlag | uvAny | pllUnlocked | enableNSync;
	assign clearEvent = histClearPulse | enableNSync;

	// Each output has its own persistence counter; any return into band restarts it.
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi = gi + 1) begin : dcTimer
			wire outOfBand;
			reg [31:0] count_reg;
			assign outOfBand = dcHighSync[gi] | dcLowSync[gi];
			always @(posedge clock) begin
				if (reset) begin
					count_reg <= 32'h00000000;
				end else if (!outOfBand || !switching || !dcProtEnable) begin
					count_reg <= 32'h00000000;
				end else if (count_reg <= DC_PERSIST_CYCLES) begin
					count_reg <= count_reg + 32'h00000001;
				end
			end
			assign dcTrip[gi] = count_reg > DC_PERSIST_CYCLES;
		end
	endgenerate

	always @* begin
		state_next = state_reg;
		timer_next = timer_reg;
		case (state_reg)
			S_OFF: begin
				if (!holdOff && !dcLatched_reg && !shortLatched_reg) begin
					state_next = S_CHECK;
					timer_next = 32'h00000000;
				end
			end
			S_CHECK: begin
				timer_next = timer_reg + 32'h00000001;
				if (holdOff) begin
					state_next = S_OFF;
				end else if (shortSync) begin
					state_next = S_LATCHED;
				end else if (timer_reg >= SHORT_CHECK_CYCLES - 32'h00000001) begin
					state_next = S_RUN;
				end
			end
			S_RUN: begin
				if (holdOff) begin
					state_next = S_OFF;
				end else if (ocEvent) begin
					state_next = S_OC_HOLD;
					timer_next = 32'h00000000;
				end else if (dcTrip != 4'h0) begin
					state_next = S_LATCHED;
				end
			end
			S_OC_HOLD: begin
				if (timer_reg < OC_RESTART_CYCLES) begin
					timer_next = timer_reg + 32'h00000001;
				end
				if (clearEvent) begin
					state_next = S_OFF;
				end else if (!ocLatchMode && timer_reg >= OC_RESTART_CYCLES && !holdOff) begin
					state_next = S_CHECK;
					timer_next = 32'h00000000;
				end
			end
			S_LATCHED: begin
				if (clearEvent) begin
					state_next = S_OFF;
				end
			end
			default: begin
				state_next = S_OFF;
				timer_next = 32'h00000000;
			end
		endcase
	end

	always @(posedge clock) begin
		if (reset) begin
			state_reg <= S_OFF;
			timer_reg <= 32'h00000000;
			switchEnable <= 1'b0;
			shortCheckEnable <= 1'b0;
		end else begin
			state_reg <= state_next;
			timer_reg <= timer_next;
			switchEnable <= (state_next == S_RUN);
			shortCheckEnable <= (state_next == S_CHECK);
		end
	end

	// Fault latches: a new fault in the same cycle as a clear is kept.
	always @(posedge clock) begin
		if (reset) begin
			dcLatched_reg <= 1'b0;
			shortLatched_reg <= 1'b0;
			ocLatched_reg <= 1'b0;
		end else begin
			if (state_reg == S_RUN && !holdOff && !ocEvent && dcTrip != 4'h0) begin
				dcLatched_reg <= 1'b1;
			end else if (clearEvent) begin
				dcLatched_reg <= 1'b0;
			end
			if (state_reg == S_CHECK && !holdOff && shortSync) begin
				shortLatched_reg <= 1'b1;
			end else if (clearEvent) begin
				shortLatched_reg <= 1'b0;
			end
			if (ocEvent && !holdOff) begin
				ocLatched_reg <= 1'b1;
			end else if (clearEvent || (state_reg == S_OC_HOLD && state_next == S_CHECK)) begin
				ocLatched_reg <= 1'b0;
			end
		end
	end

	assign errLive = {dcLatched_reg, shortLatched_reg, tempErrorFlag, tempWarningFlag,
		uvAny, pllUnlocked, ocLatched_reg, flyCapSync};

	// The pin is only ever pulled low; the external pull-up provides the high level.
	assign errorPinOut = 1'b0;

	always @(posedge clock) begin
		if (reset) begin
			errorPinOe <= 1'b0;
			irq <= 1'b0;
		end else begin
			errorPinOe <= (errLive != 8'h00);
			irq <= ((intStatus_reg & intEnable_reg) != 8'h00);
		end
	end

	// Software side. The history clear acts on any change of its bit, in either direction.
	always @(posedge clock) begin
		if (reset) begin
			dcShutdownCtrl_reg <= `DC_SHUTDOWN_CTRL_RESET;
			histCtrl_reg <= `ERR_HIST_CTRL_RESET;
			protCtrl_reg <= `PROT_CTRL_RESET;
			intEnable_reg <= `INT_ENABLE_RESET;
			histClearPulse <= 1'b0;
		end else begin
			histClearPulse <= 1'b0;
			if (wrHit(regAddr, `ADDR_DC_SHUTDOWN_CTRL, regWrite)) begin
				dcShutdownCtrl_reg <= regWrData;
			end
			if (wrHit(regAddr, `ADDR_ERR_HIST_CTRL, regWrite)) begin
				histCtrl_reg <= regWrData;
				histClearPulse <= regWrData[`HIST_CLEAR_BIT] != histCtrl_reg[`HIST_CLEAR_BIT];
			end
			if (wrHit(regAddr, `ADDR_PROT_CTRL, regWrite)) begin
				protCtrl_reg <= regWrData;
			end
			if (wrHit(regAddr, `ADDR_INT_ENABLE, regWrite)) begin
				intEnable_reg <= regWrData;
			end
		end
	end

	always @(posedge clock) begin
		if (reset) begin
			errAcc_reg <= 8'h00;
			intStatus_reg <= 8'h00;
		end else begin
			errAcc_reg <= (histClearPulse ? 8'h00 : errAcc_reg) | errLive;
			if (wrHit(regAddr, `ADDR_INT_CLEAR, regWrite)) begin
				intStatus_reg <= (intStatus_reg & ~regWrData) | errLive;
			end else begin
				intStatus_reg <= intStatus_reg | errLive;
			end
		end
	end

	always @(posedge clock) begin
		if (reset) begin
			regRdData <= 8'h00;
		end else if (regRead) begin
			case (regAddr)
				`ADDR_DC_SHUTDOWN_CTRL: regRdData <= dcShutdownCtrl_reg;
				`ADDR_ERR_HIST_CTRL: regRdData <= histCtrl_reg;
				`ADDR_INT_ENABLE: regRdData <= intEnable_reg;
				`ADDR_PROT_CTRL: regRdData <= protCtrl_reg;
				`ADDR_ERR_ACC: regRdData <= errAcc_reg;
				`ADDR_ERR_LIVE: regRdData <= errLive;
				`ADDR_INT_STATUS: regRdData <= intStatus_reg;
				default: regRdData <= 8'h00;
			endcase
		end else begin
			regRdData <= 8'h00;
		end
	end
endmodule

// *** amp_fault_manager_asserts.sv ***
// Concurrent checks on the ports of the amplifier fault supervisor.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/1ps
module amp_fault_manager_asserts (
	input wire clock,
	input wire reset,
	input wire [6:0] regAddr,
	input wire regRead,
	input wire [7:0] regRdData,
	input wire [7:0] tempCode,
	input wire [12:0] dvddMv,
	input wire [3:0] outputSwitchNodeOc,
	input wire [3:0] switchOn,
	input wire pinShortDetect,
	input wire switchEnable,
	input wire shortCheckEnable,
	input wire errorPinOut,
	input wire errorPinOe
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (reset);
	property p_oc_stop;
		(switchEnable && |(outputSwitchNodeOc & switchOn))[*3] |-> ##[0:5] !switchEnable;
	endproperty
	a_oc_stop: assert property (p_oc_stop) else $error("stage kept switching on overcurrent");
	property p_check_excl;
		shortCheckEnable |-> !switchEnable;
	endproperty
	a_check_excl: assert property (p_check_excl) else $error("switching during short check");
	property p_short_refuse;
		($rose(shortCheckEnable) && pinShortDetect) ##1 pinShortDetect[*4] |->
			##[0:6] (!shortCheckEnable && !switchEnable)[*4];
	endproperty
	a_short_refuse: assert property (p_short_refuse) else $error("start not refused on short");
	property p_warn_read;
		(tempCode >= 8'h7D)[*3] ##0 (regRead && regAddr == 7'h7C) |=> regRdData[4];
	endproperty
	a_warn_read: assert property (p_warn_read) else $error("warning bit not read back");
	property p_temp_stop;
		tempCode >= 8'h96 |-> ##[1:3] !switchEnable;
	endproperty
	a_temp_stop: assert property (p_temp_stop) else $error("switching at temperature error");
	property p_warn_pin;
		tempCode >= 8'h7D |-> ##[1:3] errorPinOe;
	endproperty
	a_warn_pin: assert property (p_warn_pin) else $error("fault pin idle at warning");
	property p_uv_stop;
		dvddMv <= 13'h0FA0 |-> ##[1:3] !switchEnable;
	endproperty
	a_uv_stop: assert property (p_uv_stop) else $error("switching under lockout");
	property p_pin_low;
		$fell(switchEnable) && |outputSwitchNodeOc |-> ##[0:2] (errorPinOe && !errorPinOut);
	endproperty
	a_pin_low: assert property (p_pin_low) else $error("fault pin idle on overcurrent");
	c_oc: cover property ($fell(switchEnable) && |outputSwitchNodeOc);
	c_short: cover property (shortCheckEnable && pinShortDetect);
	c_temp: cover property (tempCode >= 8'h96 && !switchEnable);
endmodule

// *** amp_stage_model.sv ***
// Behavioural power stage and fault pin pull-up facing the supervisor.
// Assumes the bench asks for an overload through ocReq.
`timescale 1ns/1ps
module amp_stage_model (
	input wire clock,
	input wire switchEnable,
	input wire errorPinOut,
	input wire errorPinOe,
	input wire ocReq,
	output logic [3:0] switchOn,
	output wire [3:0] outputSwitchNodeOc,
	output wire faultN
);
	initial switchOn = 4'h0;
	always @(posedge clock) begin
		switchOn <= switchEnable ? 4'hF : 4'h0;
	end
	// An overload only shows on switches that conduct.
	assign outputSwitchNodeOc = ocReq ? switchOn : 4'h0;
	assign faultN = errorPinOe ? errorPinOut : 1'b1;
endmodule

// *** tb_amp_fault_manager.sv ***
// Self-checking bench for the amplifier fault supervisor.
// Assumes short DC and restart counts set through the parameters below.
`timescale 1ns/1ps
module tb_amp_fault_manager;
	logic clock = 0;
	logic reset = 1;
	logic [6:0] regAddr = 7'h00;
	logic [7:0] regWrData = 8'h00;
	logic [7:0] tempCode = 8'h19;
	logic regWrite = 0, regRead = 0, enableN = 0, pinShortDetect = 0, ocReq = 0;
	logic flyCapFault = 0, pllUnlocked = 0;
	logic [12:0] dvddMv = 13'h1388, avddMv = 13'h1388, pvddMv = 13'h1388;
	logic [3:0] dcHighCmp = 4'h0, dcLowCmp = 4'h0;
	logic [7:0] tTab [8] = '{8'h7C, 8'h7D, 8'h95, 8'h96, 8'h88, 8'h87, 8'h6A, 8'h69};
	logic [7:0] fTab [8] = '{8'h00, 8'h10, 8'h10, 8'h30, 8'h30, 8'h10, 8'h10, 8'h00};
	logic [12:0] uTab [6] = '{13'h0FD2, 13'h10CB, 13'h10CC, 13'h0F6E, 13'h1067, 13'h1068};
	wire [7:0] regRdData;
	wire [3:0] switchOn, outputSwitchNodeOc;
	wire switchEnable, shortCheckEnable, errorPinOut, errorPinOe, irq, faultN;
	int error_cnt = 0;
	int n_checks = 0;
	always #10 clock = ~clock;
	amp_fault_manager #(.DC_PERSIST_CYCLES(32'h14), .OC_RESTART_CYCLES(32'h0A)) uut (
		.clock(clock), .reset(reset), .regAddr(regAddr), .regWrData(regWrData),
		.regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .tempCode(tempCode),
		.dvddMv(dvddMv), .avddMv(avddMv), .pvddMv(pvddMv), .enableN(enableN),
		.outputSwitchNodeOc(outputSwitchNodeOc), .switchOn(switchOn),
		.pinShortDetect(pinShortDetect), .dcHighCmp(dcHighCmp), .dcLowCmp(dcLowCmp),
		.flyCapFault(flyCapFault), .pllUnlocked(pllUnlocked), .switchEnable(switchEnable),
		.shortCheckEnable(shortCheckEnable), .errorPinOut(errorPinOut),
		.errorPinOe(errorPinOe), .irq(irq));
	amp_stage_model stage (.clock(clock), .switchEnable(switchEnable), .errorPinOut(errorPinOut),
		.errorPinOe(errorPinOe), .ocReq(ocReq), .switchOn(switchOn),
		.outputSwitchNodeOc(outputSwitchNodeOc), .faultN(faultN));
	task check(string nm, logic [7:0] got, logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task wr(logic [6:0] a, logic [7:0] d);
		@(posedge clock);
		regAddr <= a;
		regWrData <= d;
		regWrite <= 1'b1;
		@(posedge clock);
		regWrite <= 1'b0;
	endtask
	task rd(logic [6:0] a, logic [7:0] m, logic [7:0] e);
		@(posedge clock);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge clock);
		regRead <= 1'b0;
		#1;
		check($sformatf("reg %h", a), regRdData & m, e);
	endtask
	task settle;
		repeat (4) @(posedge clock);
		#1;
	endtask
	// Bounded wait, so a stage that never restarts shows up as one mismatch.
	task waitSw(logic v, int lim);
		for (int i = 0; i < lim && switchEnable !== v; i++) begin
			@(posedge clock);
			#1;
		end
		check("switchEnable", {7'h00, switchEnable}, {7'h00, v});
	endtask
	task test_done;
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clock);
		error_cnt++;
		test_done;
	end
	initial begin
		repeat (20) @(posedge clock);
		reset <= 1'b0;
		rd(7'h26, 8'hFF, 8'h04);
		rd(7'h2D, 8'hFF, 8'h00);
		rd(7'h10, 8'hFF, 8'h00);
		wr(7'h7C, 8'hFF);
		rd(7'h7C, 8'hFF, 8'h00);
		waitSw(1, 300);
		ocReq <= 1'b1;
		waitSw(0, 20);
		rd(7'h7C, 8'h02, 8'h02);
		check("faultN", {7'h00, faultN}, 8'h00);
		ocReq <= 1'b0;
		waitSw(1, 300);
		rd(7'h6D, 8'h02, 8'h02);
		for (int i = 0; i < 8; i++) begin
			tempCode <= tTab[i];
			settle;
			rd(7'h7C, 8'h30, fTab[i]);
			check("faultN", {7'h00, faultN}, {7'h00, fTab[i] == 8'h00});
		end
		waitSw(1, 300);
		wr(7'h52, 8'hFF);
		wr(7'h51, 8'h10);
		tempCode <= 8'h82;
		settle;
		check("irq", {7'h00, irq}, 8'h01);
		rd(7'h7D, 8'h10, 8'h10);
		wr(7'h51, 8'h00);
		tempCode <= 8'h19;
		settle;
		check("irq", {7'h00, irq}, 8'h00);
		wr(7'h51, 8'h10);
		settle;
		check("irq", {7'h00, irq}, 8'h01);
		wr(7'h52, 8'h10);
		settle;
		check("irq", {7'h00, irq}, 8'h00);
		for (int i = 0; i < 9; i++) begin
			if (i < 3) pvddMv <= uTab[i];
			else if (i < 6) dvddMv <= uTab[i];
			else avddMv <= uTab[i - 3];
			settle;
			rd(7'h7C, 8'h08, (i % 3 == 2) ? 8'h00 : 8'h08);
		end
		waitSw(1, 300);
		pinShortDetect <= 1'b1;
		enableN <= 1'b1;
		settle;
		enableN <= 1'b0;
		repeat (200) @(posedge clock);
		#1;
		check("switchEnable", {7'h00, switchEnable}, 8'h00);
		rd(7'h7C, 8'h40, 8'h40);
		check("faultN", {7'h00, faultN}, 8'h00);
		pinShortDetect <= 1'b0;
		wr(7'h2D, 8'h04);
		waitSw(1, 300);
		// The short latch is still live in the cycle of the first clear, so it re-enters history.
		wr(7'h2D, 8'h00);
		rd(7'h6D, 8'hFF, 8'h00);
		// Two short excursions that only add up past the limit if the timer never restarts.
		repeat (2) begin
			dcHighCmp <= 4'h1;
			repeat (12) @(posedge clock);
			dcHighCmp <= 4'h0;
			settle;
		end
		rd(7'h7C, 8'h80, 8'h00);
		dcHighCmp <= 4'h1;
		waitSw(0, 60);
		rd(7'h7C, 8'h80, 8'h80);
		check("faultN", {7'h00, faultN}, 8'h00);
		dcHighCmp <= 4'h0;
		repeat (150) @(posedge clock);
		#1;
		check("switchEnable", {7'h00, switchEnable}, 8'h00);
		wr(7'h2D, 8'h04);
		waitSw(1, 300);
		wr(7'h26, 8'h00);
		dcLowCmp <= 4'h2;
		repeat (60) @(posedge clock);
		#1;
		check("switchEnable", {7'h00, switchEnable}, 8'h01);
		rd(7'h7C, 8'h80, 8'h00);
		dcLowCmp <= 4'h0;
		pllUnlocked <= 1'b1;
		waitSw(0, 20);
		rd(7'h7C, 8'h04, 8'h04);
		pllUnlocked <= 1'b0;
		flyCapFault <= 1'b1;
		settle;
		rd(7'h7C, 8'h05, 8'h01);
		check("faultN", {7'h00, faultN}, 8'h00);
		flyCapFault <= 1'b0;
		waitSw(1, 300);
		// Latching mode: an overload holds the stage off until the enable pin is cycled.
		wr(7'h53, 8'h01);
		rd(7'h53, 8'hFF, 8'h01);
		ocReq <= 1'b1;
		waitSw(0, 20);
		ocReq <= 1'b0;
		repeat (150) @(posedge clock);
		#1;
		check("switchEnable", {7'h00, switchEnable}, 8'h00);
		rd(7'h7C, 8'h02, 8'h02);
		enableN <= 1'b1;
		settle;
		enableN <= 1'b0;
		waitSw(1, 300);
		rd(7'h7C, 8'h02, 8'h00);
		test_done;
	end
endmodule
bind amp_fault_manager amp_fault_manager_asserts chk (.clock(clock), .reset(reset),
	.regAddr(regAddr), .regRead(regRead), .regRdData(regRdData), .tempCode(tempCode),
	.dvddMv(dvddMv), .outputSwitchNodeOc(outputSwitchNodeOc), .switchOn(switchOn),
	.pinShortDetect(pinShortDetect), .switchEnable(switchEnable),
	.shortCheckEnable(shortCheckEnable), .errorPinOut(errorPinOut), .errorPinOe(errorPinOe));
